// File: rtl/uart_msr_pkg.sv
package uart_msr_pkg;

  // ------------------------------------------------------------
  // Register offsets (word index on the plain port)
  // ------------------------------------------------------------
  localparam logic [3:0] OFF_MODEM_CONTROL = 4'h4;
  localparam logic [3:0] OFF_LINE_CONTROL = 4'h3;
  localparam logic [3:0] OFF_FIFO_CONTROL = 4'h2;
  localparam logic [3:0] OFF_STATUS_THRESH = 4'h6;
  localparam logic [3:0] OFF_SCRATCH_TRIG = 4'h7;
  localparam logic [3:0] OFF_FEATURE = 4'h8;
  localparam logic [3:0] OFF_FILL = 4'h9;
  localparam logic [3:0] OFF_FLOW_STATUS = 4'ha;

  // ------------------------------------------------------------
  // Reset values and fixed codes
  // ------------------------------------------------------------
  localparam logic [7:0] RST_THRESH = 8'h00;
  localparam logic [7:0] RST_XOFF = 8'h00;
  localparam logic [7:0] RST_TRIG = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'hff;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] LINE_CTRL_UNLOCK = 8'hbf;
  localparam logic [7:0] SPECIAL_UNLOCK = 8'h5a;
  localparam logic [7:0] ZERO8 = 8'h00;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_SEL = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;
  localparam int LC_DLAB = 7;
  localparam int EF_ENH = 4;
  localparam int EF_AUTO_RTS = 6;
  localparam int EF_AUTO_SW = 3;
  localparam int EF_MSI_EN = 0;
  localparam int SF_SEL = 2;
  localparam int LVL_SHIFT = 2;

endpackage : uart_msr_pkg

// File: rtl/uart_line_sync.sv
`timescale 1ns/100ps
`default_nettype none

module uart_line_sync #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ------------------------------------------------------------
  // Two-stage synchroniser, one per line; pins idle high
  // ------------------------------------------------------------
  for (genvar g = 0; g < WIDTH; g++) begin : g_sync
    logic meta_q;
    logic stab_q;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta_q <= 1'b1;
        stab_q <= 1'b1;
      end else begin
        meta_q <= async_i[g];
        stab_q <= meta_q;
      end
    end
    assign sync_o[g] = stab_q;
  end

endmodule // uart_line_sync

`default_nettype wire

// File: rtl/uart_modem_flow_regs.sv
`timescale 1ns/100ps
`default_nettype none

module uart_modem_flow_regs #(
  parameter int FIFO_DEPTH = 64,
  parameter int LVLW = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic ri_n_i,
  input wire logic cd_n_i,
  input wire logic [LVLW-1:0] rx_fill_i,
  input wire logic [LVLW-1:0] tx_space_i,
  output logic rts_n_o,
  output logic loopback_o,
  output logic modem_irq_o,
  output logic rx_ready_irq_o,
  output logic tx_ready_irq_o,
  output logic send_xon_o,
  output logic send_xoff_o
);
  import uart_msr_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {FLOW_RUN = 2'b01, FLOW_HALT = 2'b10} flow_state_t;

  logic [7:0] modem_control_q, line_control_q, fifo_control_q;
  logic [7:0] enhanced_feature_control_q, extra_feature_select_q;
  logic [7:0] special_feature_unlock_q, flow_halt_resume_levels_q;
  logic [7:0] fifo_trigger_levels_q, xoff_char_one_q, xoff_char_two_q;
  logic [7:0] scratchpad_q, modem_line_status, rdata_d;
  logic [3:0] delta_q, lines_prev_q, lines_s, lines_now, status_hi;
  logic loop, base_page, thresh_sel, trig_sel, xoff_char_one_sel, xoff_char_two_sel;
  logic status_rd;
  logic [LVLW-1:0] resume_lvl, halt_lvl, rx_trig, tx_trig;
  logic [LVLW-1:0] rx_fill_q, tx_space_q;
  logic [3:0][LVLW-1:0] legacy_rx, legacy_tx;
  flow_state_t flow_q;

  // ------------------------------------------------------------
  // Pin synchroniser: {cd, ri, dsr, cts}
  // ------------------------------------------------------------
  uart_line_sync #(
    .WIDTH(4)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({cd_n_i, ri_n_i, dsr_n_i, cts_n_i}),
    .sync_o(lines_s)
  );

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  assign loop = modem_control_q[MC_LOOP];
  assign base_page = !line_control_q[LC_DLAB];
  assign thresh_sel = enhanced_feature_control_q[EF_ENH] &&
                      modem_control_q[MC_SEL] && !loop &&
                      !extra_feature_select_q[SF_SEL];
  assign trig_sel = enhanced_feature_control_q[EF_ENH] &&
                    modem_control_q[MC_SEL] && !loop;
  assign xoff_char_one_sel = (line_control_q == LINE_CTRL_UNLOCK) &&
                     !extra_feature_select_q[SF_SEL];
  assign xoff_char_two_sel = (line_control_q == LINE_CTRL_UNLOCK) &&
                     (special_feature_unlock_q != SPECIAL_UNLOCK);
  assign status_rd = rd_i && addr_i == OFF_STATUS_THRESH && base_page &&
                     !thresh_sel && !xoff_char_one_sel &&
                     !extra_feature_select_q[SF_SEL];

  // ------------------------------------------------------------
  // Modem status, active-high view of lines
  // ------------------------------------------------------------
  assign lines_now = ~lines_s;
  assign status_hi = loop ?
                     {modem_control_q[MC_OUT2], modem_control_q[MC_SEL],
                      modem_control_q[MC_DTR], modem_control_q[MC_RTS]} :
                     lines_now;
  assign modem_line_status = {status_hi, delta_q};

  // Change flags; a new change wins over a read clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lines_prev_q <= 4'h0;
      delta_q <= 4'h0;
    end else begin
      lines_prev_q <= status_hi;
      delta_q[3] <= (status_rd ? 1'b0 : delta_q[3]) |
                    (status_hi[3] ^ lines_prev_q[3]);
      delta_q[2] <= (status_rd ? 1'b0 : delta_q[2]) |
                    (!status_hi[2] && lines_prev_q[2]);
      delta_q[1] <= (status_rd ? 1'b0 : delta_q[1]) |
                    (status_hi[1] ^ lines_prev_q[1]);
      delta_q[0] <= (status_rd ? 1'b0 : delta_q[0]) |
                    (status_hi[0] ^ lines_prev_q[0]);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      modem_irq_o <= 1'b0;
    end else begin
      modem_irq_o <= (|delta_q) &&
                     enhanced_feature_control_q[EF_MSI_EN] &&
                     !status_rd;
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      modem_control_q <= RST_CTRL;
      line_control_q <= RST_CTRL;
      fifo_control_q <= RST_CTRL;
      enhanced_feature_control_q <= RST_CTRL;
      extra_feature_select_q <= RST_CTRL;
      special_feature_unlock_q <= RST_CTRL;
    end else if (wr_i) begin
      case (addr_i)
        OFF_MODEM_CONTROL: modem_control_q <= wdata_i;
        OFF_LINE_CONTROL: line_control_q <= wdata_i;
        OFF_FIFO_CONTROL: fifo_control_q <= wdata_i;
        OFF_FEATURE: enhanced_feature_control_q <= wdata_i;
        OFF_FILL: extra_feature_select_q <= wdata_i;
        OFF_FLOW_STATUS: special_feature_unlock_q <= wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flow_halt_resume_levels_q <= RST_THRESH;
      xoff_char_one_q <= RST_XOFF;
      fifo_trigger_levels_q <= RST_TRIG;
      xoff_char_two_q <= RST_XOFF;
      scratchpad_q <= RST_SCRATCH;
    end else if (wr_i) begin
      if (addr_i == OFF_STATUS_THRESH) begin
        if (xoff_char_one_sel) begin
          xoff_char_one_q <= wdata_i;
        end else if (thresh_sel) begin
          flow_halt_resume_levels_q <= wdata_i;
        end
      end else if (addr_i == OFF_SCRATCH_TRIG) begin
        if (xoff_char_two_sel) begin
          xoff_char_two_q <= wdata_i;
        end else if (trig_sel) begin
          fifo_trigger_levels_q <= wdata_i;
        end else if (base_page) begin
          scratchpad_q <= wdata_i;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Read mux, data one cycle after strobe
  // ------------------------------------------------------------
  always_comb begin
    rdata_d = ZERO8;
    case (addr_i)
      OFF_MODEM_CONTROL: rdata_d = modem_control_q;
      OFF_LINE_CONTROL: rdata_d = line_control_q;
      OFF_FIFO_CONTROL: rdata_d = fifo_control_q;
      OFF_FEATURE: rdata_d = enhanced_feature_control_q;
      OFF_FILL: rdata_d = extra_feature_select_q;
      OFF_FLOW_STATUS: rdata_d = {6'h00, flow_q == FLOW_HALT, loop};
      OFF_STATUS_THRESH: begin
        if (xoff_char_one_sel) begin
          rdata_d = xoff_char_one_q;
        end else if (thresh_sel) begin
          rdata_d = flow_halt_resume_levels_q;
        end else if (status_rd) begin
          rdata_d = modem_line_status;
        end
      end
      OFF_SCRATCH_TRIG: begin
        if (xoff_char_two_sel) begin
          rdata_d = xoff_char_two_q;
        end else if (trig_sel) begin
          rdata_d = fifo_trigger_levels_q;
        end else if (base_page) begin
          rdata_d = scratchpad_q;
        end
      end
      default: rdata_d = ZERO8;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= ZERO8;
    end else begin
      rdata_o <= rd_i ? rdata_d : ZERO8;
    end
  end

  // ------------------------------------------------------------
  // Levels
  // ------------------------------------------------------------
  assign legacy_rx = {LVLW'(8'h3c), LVLW'(8'h38), LVLW'(8'h10),
                      LVLW'(8'h08)};
  assign legacy_tx = {LVLW'(8'h38), LVLW'(8'h20), LVLW'(8'h10),
                      LVLW'(8'h08)};

  assign resume_lvl = LVLW'(flow_halt_resume_levels_q[7:4]) << LVL_SHIFT;
  assign halt_lvl = LVLW'(flow_halt_resume_levels_q[3:0]) << LVL_SHIFT;
  assign rx_trig = (fifo_trigger_levels_q[7:4] == 4'h0) ?
                   legacy_rx[fifo_control_q[7:6]] :
                   LVLW'(fifo_trigger_levels_q[7:4]) << LVL_SHIFT;
  assign tx_trig = (fifo_trigger_levels_q[3:0] == 4'h0) ?
                   legacy_tx[fifo_control_q[5:4]] :
                   LVLW'(fifo_trigger_levels_q[3:0]) << LVL_SHIFT;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_fill_q <= '0;
      tx_space_q <= '0;
      rx_ready_irq_o <= 1'b0;
      tx_ready_irq_o <= 1'b0;
    end else begin
      rx_fill_q <= rx_fill_i;
      tx_space_q <= tx_space_i;
      rx_ready_irq_o <= rx_fill_q >= rx_trig;
      tx_ready_irq_o <= tx_space_q >= tx_trig;
    end
  end

  // ------------------------------------------------------------
  // Automatic flow control
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flow_q <= FLOW_RUN;
      send_xon_o <= 1'b0;
      send_xoff_o <= 1'b0;
    end else begin
      send_xon_o <= 1'b0;
      send_xoff_o <= 1'b0;
      case (flow_q)
        FLOW_RUN: begin
          if (rx_fill_q >= halt_lvl && halt_lvl != '0) begin
            flow_q <= FLOW_HALT;
            send_xoff_o <= enhanced_feature_control_q[EF_AUTO_SW];
          end
        end
        FLOW_HALT: begin
          if (rx_fill_q <= resume_lvl) begin
            flow_q <= FLOW_RUN;
            send_xon_o <= enhanced_feature_control_q[EF_AUTO_SW];
          end
        end
        default: flow_q <= FLOW_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rts_n_o <= 1'b1;
      loopback_o <= 1'b0;
    end else begin
      loopback_o <= loop;
      if (enhanced_feature_control_q[EF_AUTO_RTS]) begin
        rts_n_o <= (flow_q == FLOW_HALT) || loop;
      end else begin
        rts_n_o <= !modem_control_q[MC_RTS] || loop;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_loop_cts;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    loop |-> modem_line_status[4] == modem_control_q[MC_RTS];
  endproperty
  a_loop_cts: assert property (p_loop_cts)
    else $error("loopback cts status wrong");
  property p_ri_rise_only;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (!loop && $rose(status_hi[2]) && !delta_q[2]) |=> !delta_q[2];
  endproperty
  a_ri_rise_only: assert property (p_ri_rise_only)
    else $error("ring flag set on wrong edge");
  property p_dsr_delta;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $changed(status_hi[1]) |=> delta_q[1];
  endproperty
  a_dsr_delta: assert property (p_dsr_delta)
    else $error("dsr change flag missing");
  property p_read_clears;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (status_rd && $stable(status_hi)) |=> delta_q == 4'h0;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read did not clear flags");
  property p_msi;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (|delta_q && enhanced_feature_control_q[EF_MSI_EN] && !status_rd)
      |=> modem_irq_o;
  endproperty
  a_msi: assert property (p_msi)
    else $error("modem interrupt not raised");
  property p_rx_irq;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $stable(rx_trig) |=>
      rx_ready_irq_o == ($past(rx_fill_q) >= $past(rx_trig));
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("receive interrupt level wrong");
  property p_halt;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (flow_q == FLOW_RUN && halt_lvl != '0 && rx_fill_q >= halt_lvl)
      |=> flow_q == FLOW_HALT;
  endproperty
  a_halt: assert property (p_halt)
    else $error("flow did not halt");
  property p_scratch_wr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == OFF_SCRATCH_TRIG && base_page && !trig_sel &&
     !xoff_char_two_sel) |=> scratchpad_q == $past(wdata_i);
  endproperty
  a_scratch_wr: assert property (p_scratch_wr)
    else $error("scratchpad write lost");

endmodule // uart_modem_flow_regs

`default_nettype wire

// File: tb/modem_line_model.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Modem side: active-low status pins, moved off the clock edge
// ------------------------------------------------------------
module modem_line_model (
  input wire logic ref_clk_i,
  input wire logic [3:0] assert_i,
  output logic cts_n_o,
  output logic dsr_n_o,
  output logic ri_n_o,
  output logic cd_n_o
);
  initial begin
    {cd_n_o, ri_n_o, dsr_n_o, cts_n_o} = 4'hf;
    forever begin
      @(posedge ref_clk_i);
      #7;
      {cd_n_o, ri_n_o, dsr_n_o, cts_n_o} = ~assert_i;
    end
  end
endmodule // modem_line_model

`default_nettype wire

// File: tb/uart_modem_flow_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none

module uart_modem_flow_regs_tb;
  import uart_msr_pkg::*;
  logic ref_clk_i, rst_n_i, wr_i, rd_i;
  logic [3:0] addr_i, lines;
  logic [7:0] wdata_i, rdata_o, rx_fill_i, tx_space_i, rd_mask;
  logic cts_n, dsr_n, ri_n, cd_n, rts_n_o, loopback_o, modem_irq_o;
  logic rx_ready_irq_o, tx_ready_irq_o, send_xon_o, send_xoff_o;
  int mismatches, comparisons, xon_cnt, xoff_cnt, i, m;
  logic [3:0] pin_seq [6];
  logic [7:0] msr_seq [6];
  logic [7:0] fill_seq [4];
  logic rts_seq [4];

  uart_modem_flow_regs #(.FIFO_DEPTH(64), .LVLW(8)) i_uart_modem_flow_regs (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cts_n_i(cts_n), .dsr_n_i(dsr_n), .ri_n_i(ri_n), .cd_n_i(cd_n),
    .rx_fill_i(rx_fill_i), .tx_space_i(tx_space_i), .rts_n_o(rts_n_o),
    .loopback_o(loopback_o), .modem_irq_o(modem_irq_o),
    .rx_ready_irq_o(rx_ready_irq_o), .tx_ready_irq_o(tx_ready_irq_o),
    .send_xon_o(send_xon_o), .send_xoff_o(send_xoff_o));

  modem_line_model i_modem_line_model (.ref_clk_i(ref_clk_i),
    .assert_i(lines), .cts_n_o(cts_n), .dsr_n_o(dsr_n), .ri_n_o(ri_n),
    .cd_n_o(cd_n));

  // ------------------------------------------------------------
  // Clock, pulse counters, watchdog
  // ------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    if (send_xon_o === 1'b1) xon_cnt++;
    if (send_xoff_o === 1'b1) xoff_cnt++;
  end

  initial begin
    repeat (100000) @(posedge ref_clk_i);
    mismatches++;
    $display("watchdog expired");
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp,
                        input string what);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    check(what, rdata_o & rd_mask, exp & rd_mask);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic lvl(input logic [7:0] rx, input logic [7:0] tx,
                     input logic er, input logic et);
    @(posedge ref_clk_i);
    rx_fill_i <= rx;
    tx_space_i <= tx;
    settle(4);
    check("rx ready irq", {7'h00, rx_ready_irq_o}, {7'h00, er});
    check("tx ready irq", {7'h00, tx_ready_irq_o}, {7'h00, et});
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    rx_fill_i = 8'h00;
    tx_space_i = 8'h00;
    lines = 4'h0;
    rd_mask = 8'hff;
    mismatches = 0;
    comparisons = 0;
    xon_cnt = 0;
    xoff_cnt = 0;
    pin_seq = '{4'h1, 4'h3, 4'h7, 4'h3, 4'hb, 4'h0};
    msr_seq = '{8'h11, 8'h32, 8'h70, 8'h34, 8'hb8, 8'h0b};
    fill_seq = '{8'h0f, 8'h10, 8'h09, 8'h08};
    rts_seq = '{1'b0, 1'b1, 1'b1, 1'b0};
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    settle(4);
    reg_rd(OFF_SCRATCH_TRIG, RST_SCRATCH, "scratchpad");
    reg_wr(OFF_SCRATCH_TRIG, 8'h3c);
    reg_rd(OFF_SCRATCH_TRIG, 8'h3c, "scratchpad");
    reg_rd(4'hf, 8'h00, "unmapped");
    $display("test reset and scratchpad done");
    reg_wr(OFF_FEATURE, 8'h11);
    reg_wr(OFF_MODEM_CONTROL, 8'h04);
    reg_rd(OFF_STATUS_THRESH, RST_THRESH, "thresholds");
    reg_rd(OFF_SCRATCH_TRIG, RST_TRIG, "trigger");
    reg_wr(OFF_SCRATCH_TRIG, 8'h5a);
    reg_rd(OFF_SCRATCH_TRIG, 8'h5a, "trigger");
    reg_wr(OFF_LINE_CONTROL, LINE_CTRL_UNLOCK);
    reg_rd(OFF_STATUS_THRESH, RST_XOFF, "xoff one");
    reg_wr(OFF_STATUS_THRESH, 8'h13);
    reg_rd(OFF_STATUS_THRESH, 8'h13, "xoff one");
    reg_rd(OFF_SCRATCH_TRIG, RST_XOFF, "xoff two");
    reg_wr(OFF_SCRATCH_TRIG, 8'h93);
    reg_rd(OFF_SCRATCH_TRIG, 8'h93, "xoff two");
    reg_wr(OFF_FLOW_STATUS, SPECIAL_UNLOCK);
    reg_rd(OFF_SCRATCH_TRIG, 8'h5a, "trigger");
    reg_wr(OFF_FLOW_STATUS, 8'h00);
    reg_wr(OFF_LINE_CONTROL, 8'h00);
    reg_rd(OFF_STATUS_THRESH, RST_THRESH, "thresholds");
    reg_wr(OFF_MODEM_CONTROL, 8'h00);
    reg_rd(OFF_SCRATCH_TRIG, 8'h3c, "scratchpad");
    $display("test register selection done");
    for (i = 0; i < 6; i++) begin
      @(posedge ref_clk_i);
      lines <= pin_seq[i];
      settle(8);
      check("modem irq", {7'h00, modem_irq_o}, {7'h00, |msr_seq[i][3:0]});
      reg_rd(OFF_STATUS_THRESH, msr_seq[i], "status");
      reg_rd(OFF_STATUS_THRESH, msr_seq[i] & 8'hf0, "status");
      check("modem irq", {7'h00, modem_irq_o}, 8'h00);
    end
    $display("test modem lines done");
    reg_wr(OFF_MODEM_CONTROL, 8'h17);
    settle(8);
    check("loopback", {7'h00, loopback_o}, 8'h01);
    reg_rd(OFF_FLOW_STATUS, 8'h01, "flow status");
    rd_mask = 8'hf0;
    reg_rd(OFF_STATUS_THRESH, 8'h70, "loop status");
    reg_wr(OFF_MODEM_CONTROL, 8'h1a);
    settle(8);
    reg_rd(OFF_STATUS_THRESH, 8'h90, "loop status");
    rd_mask = 8'hff;
    reg_wr(OFF_MODEM_CONTROL, 8'h00);
    settle(4);
    check("loopback", {7'h00, loopback_o}, 8'h00);
    check("modem irq", {7'h00, modem_irq_o}, 8'h01);
    $display("test loopback done");
    reg_wr(OFF_MODEM_CONTROL, 8'h04);
    reg_wr(OFF_STATUS_THRESH, 8'h24);
    reg_wr(OFF_SCRATCH_TRIG, 8'h32);
    reg_wr(OFF_MODEM_CONTROL, 8'h00);
    for (m = 0; m < 2; m++) begin
      reg_wr(OFF_FEATURE, (m == 0) ? 8'h50 : 8'h18);
      for (i = 0; i < 4; i++) begin
        @(posedge ref_clk_i);
        rx_fill_i <= fill_seq[i];
        settle(4);
        check("rts_n", {7'h00, rts_n_o},
              {7'h00, (m == 0) ? rts_seq[i] : 1'b1});
      end
    end
    check("xoff pulses", xoff_cnt[7:0], 8'h01);
    check("xon pulses", xon_cnt[7:0], 8'h01);
    check("modem irq", {7'h00, modem_irq_o}, 8'h00);
    $display("test flow thresholds done");
    reg_wr(OFF_FEATURE, 8'h10);
    reg_wr(OFF_MODEM_CONTROL, 8'h04);
    reg_wr(OFF_SCRATCH_TRIG, 8'h32);
    lvl(8'h0b, 8'h07, 1'b0, 1'b0);
    lvl(8'h0c, 8'h08, 1'b1, 1'b1);
    reg_wr(OFF_SCRATCH_TRIG, 8'h00);
    reg_wr(OFF_FIFO_CONTROL, 8'h61);
    lvl(8'h0f, 8'h1f, 1'b0, 1'b0);
    lvl(8'h10, 8'h20, 1'b1, 1'b1);
    $display("test trigger levels done");
    tally_and_finish();
  end
endmodule // uart_modem_flow_regs_tb

`default_nettype wire
